// ---- design/mfcs_consts.vh ----
// constants of the modem function configuration space
// Summary of operation
// RL1: modem answers as configuration function one, LAN as zero, present per strap
// RL2: identity dword holds device and vendor ids, read-only, from EEPROM
// RL3: command resets zero; only bits 8, 6, 1, 0 writable, others zero
// RL4: status reads 01 in bits 10:9, one in bit 4; bits 15, 14 writable
// RL5: every writable status bit is cleared while bus reset is asserted
// RL6: class dword reports base 07h, subclass 00h, interface 02h
// RL7: revision byte 7:0 comes from EEPROM word FEh
// RL8: header type byte always reads 80h, multifunction
// RL9: I/O window base requests 8 bytes; low address bits fixed
// RL10: memory window base requests 4 KB for control and card info
// RL11: card info pointer fixed: 0010h in bits 31:4, 2h in 3:0
// RL12: subsystem vendor id read-only from EEPROM, mirrors LAN 2Ch
// RL13: subsystem id read-only from EEPROM, mirrors LAN 2Eh
// RL14: capability pointer always reads DCh
// RL15: interrupt register mirrors LAN register 3Ch contents
// RL16: modem and LAN interrupt requests share one INTA# output
// RL17: power capabilities read FE31h with aux power, else 7E21h
// RL18: power control/status laid out and behaving like LAN E0h
// RL19: data: selects 0-7 EEPROM values scale 2; 8-15 zero scale 0
// RL20: modem strap set and boot disable clear make both modem and boot ROM active
// RL21: LAN boot enable bit chooses boot ROM or modem on shared port
// RL22: no extra companion logic may sit on the shared flash/modem port
// RL23: writes to fixed fields ignored; reserved locations read zero
`ifndef MFCS_CONSTS_VH
`define MFCS_CONSTS_VH

// ******************************************************
// dword offsets
// ******************************************************
`define MFCS_OFF_IDENT 8'h00
`define MFCS_OFF_CMDSTAT 8'h04
`define MFCS_OFF_CLASS 8'h08
`define MFCS_OFF_HEADER 8'h0C
`define MFCS_OFF_IOBAR 8'h10
`define MFCS_OFF_MEMBAR 8'h14
`define MFCS_OFF_CIS 8'h28
`define MFCS_OFF_SUBSYS 8'h2C
`define MFCS_OFF_CAPPTR 8'h34
`define MFCS_OFF_INTR 8'h3C
`define MFCS_OFF_PMCAP 8'hDC
`define MFCS_OFF_PMCSR 8'hE0

// ******************************************************
// fixed values and masks
// ******************************************************
`define MFCS_FUNC_MODEM 3'h1
`define MFCS_CMD_WMASK 16'h0143
`define MFCS_STAT_WMASK 16'hC000
`define MFCS_STAT_FIXED 16'h0210
`define MFCS_CLASS_CODE 24'h07_0002
`define MFCS_HEADER_TYPE 8'h80
`define MFCS_IOBAR_WMASK 32'hFFFF_FFF8
`define MFCS_IOBAR_FIXED 32'h0000_0001
`define MFCS_MEMBAR_WMASK 32'hFFFF_F000
`define MFCS_CIS_PTR 32'h0000_0102
`define MFCS_CAP_PTR 8'hDC
`define MFCS_PMC_AUX 16'hFE31
`define MFCS_PMC_NOAUX 16'h7E21
`define MFCS_PM_CAP_ID 8'h01
`define MFCS_PM_NEXT 8'h00
`define MFCS_DATA_SCALE 2'h2
`define MFCS_PMCSR_RESET 16'h0000

// ******************************************************
// power control/status fields
// ******************************************************
`define MFCS_PM_STATUS_BIT 15
`define MFCS_PM_ENABLE_BIT 8

`endif

// ---- design/mfcs_config_space.v ----
// modem function configuration space register set
`include "mfcs_consts.vh"

module mfcs_config_space #(
  parameter PWR_BYTES = 8
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire cfg_req_in,
  input wire cfg_wr_in,
  input wire [2:0] cfg_func_in,
  input wire [7:0] cfg_addr_in,
  input wire [3:0] cfg_be_in,
  input wire [31:0] cfg_wdata_in,
  output reg [31:0] cfg_rdata_out,
  output reg cfg_ack_out,
  input wire [31:0] ee_ident_in,
  input wire [7:0] ee_revision_in,
  input wire [15:0] ee_subsys_vendor_in,
  input wire [15:0] ee_subsys_in,
  input wire [15:0] lan_interrupt_reg_in,
  input wire [63:0] ee_power_data_in,
  input wire modem_function_strap_in,
  input wire boot_rom_disable_strap_in,
  input wire aux_power_in,
  input wire cardbus_mode_in,
  input wire lan_boot_enable_in,
  input wire modem_irq_in,
  input wire lan_irq_in,
  input wire pme_event_in,
  output wire inta_n_out,
  output wire inta_n_oe_out,
  output wire pme_n_out,
  output wire pme_n_oe_out,
  output reg modem_active_out,
  output reg boot_rom_active_out,
  output wire modem_port_sel_out,
  output wire boot_rom_sel_out,
  output wire [1:0] power_state_out,
  output wire io_enable_out,
  output wire mem_enable_out
);

  // ******************************************************
  // state
  // ******************************************************
  reg [15:0] cmd_r;
  reg [15:0] cmd_nxt;
  reg [15:0] stat_r;
  reg [15:0] stat_nxt;
  reg [31:0] iobar_r;
  reg [31:0] iobar_nxt;
  reg [31:0] membar_r;
  reg [31:0] membar_nxt;
  reg [15:0] pmcsr_r;
  reg [15:0] pmcsr_nxt;
  reg straps_taken_r;
  reg [31:0] rdata_nxt;
  reg [31:0] mrg;

  wire hit;
  wire wr;
  wire [31:0] bmask;
  wire [7:0] pwr_byte;
  wire [1:0] pwr_scale;
  wire [3:0] data_sel;

  // merge byte-enabled write data into a field under a writable mask
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdata;
    input [31:0] lanes;
    input [31:0] wmask;
    begin
      merge = (old & ~(lanes & wmask)) | (wdata & lanes & wmask);
    end
  endfunction

  // ******************************************************
  // access decode
  // ******************************************************
  // only function one, and only while the strap has enabled it
  assign hit = cfg_req_in && (cfg_func_in == `MFCS_FUNC_MODEM) && modem_active_out; // see RL1
  assign wr = hit && cfg_wr_in;
  assign bmask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}}, {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};

  // ******************************************************
  // straps
  // ******************************************************
  // straps are caught by the first clock after reset release, never by the reset itself
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      straps_taken_r <= 1'b0;
      modem_active_out <= 1'b0;
      boot_rom_active_out <= 1'b0;
    end
    else if (!straps_taken_r)
    begin
      straps_taken_r <= 1'b1;
      modem_active_out <= modem_function_strap_in; // see RL1
      boot_rom_active_out <= !boot_rom_disable_strap_in; // see RL20
    end
  end

  // shared port: boot enable picks the ROM, otherwise the modem owns it
  assign boot_rom_sel_out = boot_rom_active_out && lan_boot_enable_in; // see RL21
  assign modem_port_sel_out = modem_active_out && !boot_rom_sel_out; // see RL21

  // ******************************************************
  // writable registers
  // ******************************************************
  always @*
  begin
    mrg = 32'h0000_0000;
    cmd_nxt = cmd_r;
    stat_nxt = stat_r;
    iobar_nxt = iobar_r;
    membar_nxt = membar_r;
    pmcsr_nxt = pmcsr_r;
    if (wr)
    begin
      case (cfg_addr_in & 8'hFC)
        `MFCS_OFF_CMDSTAT:
        begin
          mrg = merge({16'h0000, cmd_r}, cfg_wdata_in, bmask,
                      {16'h0000, `MFCS_CMD_WMASK});
          cmd_nxt = mrg[15:0]; // see RL3
          mrg = merge({16'h0000, stat_r}, {16'h0000, cfg_wdata_in[31:16]},
                      {16'h0000, bmask[31:16]}, {16'h0000, `MFCS_STAT_WMASK});
          stat_nxt = mrg[15:0]; // see RL4
        end
        `MFCS_OFF_IOBAR:
          iobar_nxt = merge(iobar_r, cfg_wdata_in, bmask, `MFCS_IOBAR_WMASK); // see RL9
        `MFCS_OFF_MEMBAR:
          membar_nxt = merge(membar_r, cfg_wdata_in, bmask, `MFCS_MEMBAR_WMASK); // see RL10
        `MFCS_OFF_PMCSR:
        begin
          // power state, data select and PME enable are plain writes
          mrg = merge({16'h0000, pmcsr_r}, cfg_wdata_in, bmask, 32'h0000_1F03);
          pmcsr_nxt = mrg[15:0]; // see RL18
          // PME status is write-one-to-clear
          if (bmask[15] && cfg_wdata_in[`MFCS_PM_STATUS_BIT])
            pmcsr_nxt[`MFCS_PM_STATUS_BIT] = 1'b0; // see RL18
        end
        default:
          cmd_nxt = cmd_r; // see RL23
      endcase
    end
    // a wake event in the clearing cycle still lands
    if (pme_event_in)
      pmcsr_nxt[`MFCS_PM_STATUS_BIT] = 1'b1; // see RL18
  end

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_r <= 16'h0000; // see RL3
      stat_r <= 16'h0000; // see RL5
      iobar_r <= 32'h0000_0000;
      membar_r <= 32'h0000_0000;
      pmcsr_r <= `MFCS_PMCSR_RESET;
    end
    else
    begin
      cmd_r <= cmd_nxt;
      stat_r <= stat_nxt;
      iobar_r <= iobar_nxt;
      membar_r <= membar_nxt;
      pmcsr_r <= pmcsr_nxt;
    end
  end

  // ******************************************************
  // power data
  // ******************************************************
  assign data_sel = pmcsr_r[12:9];
  // selects above seven have no table entry and report zero at scale zero
  assign pwr_byte = (data_sel < PWR_BYTES) ? ee_power_data_in[data_sel[2:0]*8 +: 8] : 8'h00; // see RL19
  assign pwr_scale = (data_sel < PWR_BYTES) ? `MFCS_DATA_SCALE : 2'h0; // see RL19

  // ******************************************************
  // read mux
  // ******************************************************
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (cfg_addr_in & 8'hFC)
      `MFCS_OFF_IDENT:
        rdata_nxt = ee_ident_in; // see RL2
      `MFCS_OFF_CMDSTAT:
        rdata_nxt = {stat_r | `MFCS_STAT_FIXED, cmd_r}; // see RL4
      `MFCS_OFF_CLASS:
        rdata_nxt = {`MFCS_CLASS_CODE, ee_revision_in}; // see RL6 RL7
      `MFCS_OFF_HEADER:
        rdata_nxt = {8'h00, `MFCS_HEADER_TYPE, 16'h0000}; // see RL8
      `MFCS_OFF_IOBAR:
        rdata_nxt = iobar_r | `MFCS_IOBAR_FIXED; // see RL9
      `MFCS_OFF_MEMBAR:
        rdata_nxt = membar_r; // see RL10
      `MFCS_OFF_CIS:
        // the pointer exists only in CardBus mode; PCI mode sees reserved zero
        rdata_nxt = cardbus_mode_in ? `MFCS_CIS_PTR : 32'h0000_0000; // see RL11
      `MFCS_OFF_SUBSYS:
        rdata_nxt = {ee_subsys_in, ee_subsys_vendor_in}; // see RL12 RL13
      `MFCS_OFF_CAPPTR:
        rdata_nxt = {24'h00_0000, `MFCS_CAP_PTR}; // see RL14
      `MFCS_OFF_INTR:
        rdata_nxt = {16'h0000, lan_interrupt_reg_in}; // see RL15
      `MFCS_OFF_PMCAP:
        rdata_nxt = {aux_power_in ? `MFCS_PMC_AUX : `MFCS_PMC_NOAUX,
                     `MFCS_PM_NEXT, `MFCS_PM_CAP_ID}; // see RL17
      `MFCS_OFF_PMCSR:
        rdata_nxt = {8'h00, pwr_byte, pmcsr_r[15], pwr_scale, pmcsr_r[12:0]}; // see RL18 RL19
      default:
        rdata_nxt = 32'h0000_0000; // see RL23
    endcase
  end

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_ack_out <= 1'b0;
    end
    else
    begin
      cfg_ack_out <= hit;
      // write cycles return zero so stale data never leaks
      cfg_rdata_out <= (hit && !cfg_wr_in) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ******************************************************
  // pins
  // ******************************************************
  // open drain: both functions pull the same line low
  assign inta_n_out = 1'b0;
  assign inta_n_oe_out = modem_irq_in || lan_irq_in; // see RL16
  assign pme_n_out = 1'b0;
  assign pme_n_oe_out = pmcsr_r[`MFCS_PM_STATUS_BIT] && pmcsr_r[`MFCS_PM_ENABLE_BIT]; // see RL18
  assign power_state_out = pmcsr_r[1:0];
  assign io_enable_out = cmd_r[0];
  assign mem_enable_out = cmd_r[1];

endmodule

// ---- bench/mfcs_config_space_chk.sv ----
// assertions on the modem config space ports
module mfcs_config_space_chk #(
  parameter PWR_BYTES = 8
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire cfg_req_in,
  input wire cfg_wr_in,
  input wire [2:0] cfg_func_in,
  input wire [7:0] cfg_addr_in,
  input wire [3:0] cfg_be_in,
  input wire [31:0] cfg_wdata_in,
  input wire [31:0] cfg_rdata_out,
  input wire cfg_ack_out,
  input wire [7:0] ee_revision_in,
  input wire modem_irq_in,
  input wire lan_irq_in,
  input wire lan_boot_enable_in,
  input wire inta_n_out,
  input wire inta_n_oe_out,
  input wire modem_active_out,
  input wire boot_rom_active_out,
  input wire modem_port_sel_out,
  input wire boot_rom_sel_out,
  input wire io_enable_out,
  input wire mem_enable_out
);
  // ****
  // checks
  // ****
  wire claim = cfg_req_in && cfg_func_in == 3'h1 && modem_active_out;
  wire rd = claim && !cfg_wr_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_ack_claimed: assert property (claim |=> cfg_ack_out)
    else $error("ack missing");
  chk_no_stray: assert property (!claim |=> !cfg_ack_out)
    else $error("ack without claim");
  chk_rdata_idle: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0)
    else $error("read data not idle");
  chk_class_code: assert property (rd && cfg_addr_in[7:2] == 6'h02
    |=> cfg_rdata_out == {24'h07_0002, $past(ee_revision_in)}) else $error("class bad");
  chk_header_kind: assert property (rd && cfg_addr_in[7:2] == 6'h03
    |=> cfg_rdata_out == 32'h0080_0000) else $error("header bad");
  chk_cmd_write: assert property (claim && cfg_wr_in && cfg_addr_in[7:2] == 6'h01
    && cfg_be_in[0] |=> {mem_enable_out, io_enable_out} == $past(cfg_wdata_in[1:0]))
    else $error("command enables bad");
  chk_shared_irq: assert property (inta_n_oe_out == (modem_irq_in || lan_irq_in)
    && !inta_n_out) else $error("shared irq bad");
  chk_port_select: assert property (boot_rom_sel_out ==
    (boot_rom_active_out && lan_boot_enable_in) && modem_port_sel_out ==
    (modem_active_out && !boot_rom_sel_out)) else $error("port select bad");
endmodule

bind mfcs_config_space mfcs_config_space_chk #(.PWR_BYTES(PWR_BYTES)) u_chk (.clk_sys_in,
  .rst_n_in, .cfg_req_in, .cfg_wr_in, .cfg_func_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in,
  .cfg_rdata_out, .cfg_ack_out, .ee_revision_in, .modem_irq_in, .lan_irq_in,
  .lan_boot_enable_in, .inta_n_out, .inta_n_oe_out, .modem_active_out, .boot_rom_active_out,
  .modem_port_sel_out, .boot_rom_sel_out, .io_enable_out, .mem_enable_out);

// ---- bench/mfcs_host_model.sv ----
// host model that issues configuration cycles
module mfcs_host_model (
  input wire clk_in,
  input wire ack_in,
  input wire [31:0] rdata_in,
  output logic req_out = 1'b0,
  output logic wr_out = 1'b0,
  output logic [2:0] func_out = 3'h0,
  output logic [7:0] addr_out = 8'h00,
  output logic [31:0] wdata_out = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // sole master of the port, one pulse per access
  task automatic access(input logic [2:0] f, input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic k);
    @(negedge clk_in);
    req_out = 1'b1;
    wr_out = w;
    func_out = f;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    q = rdata_in;
    k = ack_in;
    req_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// ---- bench/mfcs_config_space_bench.sv ----
// self-checking bench for the modem config space
module mfcs_config_space_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IDENT = 32'h1234_5678; // arbitrary identity value
  localparam logic [7:0] REV = 8'h5a;
  localparam logic [63:0] PWR = 64'h4142_4344_4546_4748;
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, bd = 1'b0, aux = 1'b0, cb = 1'b0;
  logic boot = 1'b0, mirq = 1'b0, lirq = 1'b0, req, wr, ack, k, pme = 1'b0, pme_oe;
  logic [3:0] be = 4'hf;
  logic [2:0] func;
  logic [7:0] addr;
  logic [31:0] wd, rdata, q;
  logic inta_n, inta_oe, m_act, b_act, m_sel, b_sel, io_en, mem_en;
  logic [1:0] pst;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [39:0] rows [10] = '{{8'h00, IDENT}, {8'h04, 32'h0210_0000}, {8'h08, 24'h07_0002, REV},
    {8'h0c, 32'h0080_0000}, {8'h28, 32'h0}, {8'h2c, 32'h0c0d_0a0b}, {8'h34, 32'h0000_00dc},
    {8'h3c, 32'h0000_010b}, {8'hdc, 32'h7e21_0001}, {8'h20, 32'h0}};
  mfcs_config_space u_mfcs_config_space (.clk_sys_in(clk), .rst_n_in(rst_n), .cfg_req_in(req),
    .cfg_wr_in(wr), .cfg_func_in(func), .cfg_addr_in(addr), .cfg_be_in(be),
    .cfg_wdata_in(wd), .cfg_rdata_out(rdata), .cfg_ack_out(ack), .ee_ident_in(IDENT),
    .ee_revision_in(REV), .ee_subsys_vendor_in(16'h0a0b), .ee_subsys_in(16'h0c0d),
    .lan_interrupt_reg_in(16'h010b), .ee_power_data_in(PWR), .modem_function_strap_in(strap),
    .boot_rom_disable_strap_in(bd), .aux_power_in(aux), .cardbus_mode_in(cb),
    .lan_boot_enable_in(boot), .modem_irq_in(mirq), .lan_irq_in(lirq), .pme_event_in(pme),
    .inta_n_out(inta_n), .inta_n_oe_out(inta_oe), .pme_n_out(), .pme_n_oe_out(pme_oe),
    .modem_active_out(m_act), .boot_rom_active_out(b_act), .modem_port_sel_out(m_sel),
    .boot_rom_sel_out(b_sel), .power_state_out(pst), .io_enable_out(io_en),
    .mem_enable_out(mem_en));
  mfcs_host_model u_mfcs_host_model (.clk_in(clk), .ack_in(ack), .rdata_in(rdata),
    .req_out(req), .wr_out(wr), .func_out(func), .addr_out(addr), .wdata_out(wd));
  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_mfcs_host_model.access(3'h1, 1'b0, a, 32'h0, q, k);
  endtask
  task automatic wr_all(input logic [7:0] a);
    u_mfcs_host_model.access(3'h1, 1'b1, a, 32'hffff_ffff, q, k);
  endtask
  task automatic reset_again;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial forever #50 clk = ~clk;
  initial
  begin
    #3_000_000;
    n_mismatch++;
    finish_test;
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      rd(rows[i][39:32]);
      check(q, rows[i][31:0]);
      check({31'h0, k}, 32'h1);
    end
    wr_all(8'h04);
    rd(8'h04);
    check(q, 32'hc210_0143);
    wr_all(8'h00);
    rd(8'h00);
    check(q, IDENT);
    wr_all(8'h10);
    rd(8'h10);
    check(q, 32'hffff_fff9);
    wr_all(8'h14);
    rd(8'h14);
    check(q, 32'hffff_f000);
    for (int s = 0; s < 9; s++)
    begin
      u_mfcs_host_model.access(3'h1, 1'b1, 8'he0, {19'h0, s[3:0], 9'h003}, q, k);
      rd(8'he0);
      check(q, s < 8 ? {8'h00, PWR[8*s+:8], 3'b010, s[3:0], 9'h003}
        : {19'h0, 4'h8, 9'h003});
      check({30'h0, pst}, 32'h3);
    end
    cb = 1'b1;
    aux = 1'b1;
    rd(8'h28);
    check(q, 32'h0000_0102);
    rd(8'hdc);
    check(q, 32'hfe31_0001);
    u_mfcs_host_model.access(3'h0, 1'b0, 8'h00, 32'h0, q, k);
    check({31'h0, k}, 32'h0);
    mirq = 1'b1;
    @(negedge clk);
    check({31'h0, inta_oe}, 32'h1);
    mirq = 1'b0;
    lirq = 1'b1;
    @(negedge clk);
    check({31'h0, inta_oe}, 32'h1);
    check({31'h0, inta_n}, 32'h0);
    lirq = 1'b0;
    @(negedge clk);
    check({31'h0, inta_oe}, 32'h0);
    check({30'h0, m_act, b_act}, 32'h3);
    boot = 1'b1; // host picks the boot ROM
    @(negedge clk);
    check({30'h0, b_sel, m_sel}, 32'h2);
    boot = 1'b0;
    @(negedge clk);
    check({30'h0, b_sel, m_sel}, 32'h1);
    reset_again;
    rd(8'h04);
    check(q, 32'h0210_0000);
    be = 4'h1;
    wr_all(8'h04);
    be = 4'hf;
    rd(8'h04);
    check(q, 32'h0210_0043);
    check({30'h0, mem_en, io_en}, 32'h3);
    u_mfcs_host_model.access(3'h1, 1'b1, 8'he0, 32'h0000_0100, q, k);
    pme = 1'b1;
    @(negedge clk);
    pme = 1'b0;
    check({31'h0, pme_oe}, 32'h1);
    rd(8'he0);
    check(q, 32'h0048_c100);
    pme = 1'b1; // wake event held across the clearing write: set wins
    u_mfcs_host_model.access(3'h1, 1'b1, 8'he0, 32'h0000_8100, q, k);
    pme = 1'b0;
    rd(8'he0);
    check(q, 32'h0048_c100);
    u_mfcs_host_model.access(3'h1, 1'b1, 8'he0, 32'h0000_8100, q, k);
    rd(8'he0);
    check(q, 32'h0048_4100);
    check({31'h0, pme_oe}, 32'h0);
    strap = 1'b0;
    reset_again;
    rd(8'h00);
    check({31'h0, k}, 32'h0);
    finish_test;
  end
endmodule
